// ### logic/dsr_top.sv
// Dual 128-stage recirculating shift register driven by an external shift clock pin.
// Assumes all pins are synchronous to clk_in and the shift clock is far slower than clk_in.
//
// How it works
// - Two separate 128-bit chains each have their own data inputs and serial output.
// - A single shift clock pin advances both chains on the same event.
// - Each rising edge of the shift clock enters one bit and moves every bit toward the tail.
// - Select low enters the primary data bit, select high enters the recirculation bit.
// - With the shift clock held high the stored bits stay unchanged for any time once a held edge has been taken.
// - A master stage follows the input while the clock is low and hands it on at the rise.
`timescale 1ns/10ps
module dsr_top
    import dsr_pkg::*;
#(
    parameter int STAGES = DSR_STAGES,
    parameter int LOW_LIMIT_CYCLES = DSR_LOW_MAX_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Shift clock and recirculation control
    input wire logic shift_clk_in,
    input wire logic recirculate_select_in,
    // Lane A data inputs
    input wire logic data_a_in,
    input wire logic recirc_a_in,
    // Lane B data inputs
    input wire logic data_b_in,
    input wire logic recirc_b_in,
    // Serial outputs
    output logic serial_a_out,
    output logic serial_b_out,
    // Buffered output stream of lane pairs
    output logic pair_valid_out,
    output logic [1:0] pair_data_out,
    input wire logic pair_ready_in,
    // Flow control and low-phase watch
    output logic shift_ready_out,
    output logic low_overrun_out
);
    if (STAGES < 2 || LOW_LIMIT_CYCLES < 1) begin : g_bad_params
        $error("dsr_top needs two stages and a positive low limit");
    end

    // Input selector shared by both lanes
    function automatic logic sel_bit(input logic rc, input logic d, input logic r);
        return rc ? r : d;
    endfunction

    logic clk_prev_q;
    logic [1:0] master_q;
    logic [1:0] master_d;
    logic pend_q;
    logic pend_d;
    logic rise;
    logic room;
    logic shift_en;
    logic [1:0] next_tail;
    logic [1:0] slot0_q;
    logic [1:0] slot0_d;
    logic [1:0] slot1_q;
    logic [1:0] slot1_d;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic valid_q;
    logic ready_q;
    logic pop;
    logic [31:0] low_cnt_q;
    logic [31:0] low_cnt_d;
    logic overrun_q;
    logic overrun_d;

    // Edge detect and shift gating; a held edge waits for buffer room
    assign rise = shift_clk_in & ~clk_prev_q;
    assign room = (cnt_q < 2'(DSR_BUF_DEPTH));
    assign shift_en = (rise | pend_q) & room;
    assign pop = valid_q & pair_ready_in;

    // Master stage: transparent while the clock is low, frozen while high
    always_comb begin
        master_d = master_q;
        if (!shift_clk_in) begin
            master_d[0] = sel_bit(recirculate_select_in, data_a_in, recirc_a_in);
            master_d[1] = sel_bit(recirculate_select_in, data_b_in, recirc_b_in);
        end
        pend_d = (rise | pend_q) & ~room;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            clk_prev_q <= 1'h1;
            master_q <= 2'h0;
            pend_q <= 1'h0;
        end else begin
            clk_prev_q <= shift_clk_in;
            master_q <= master_d;
            pend_q <= pend_d;
        end
    end

    // Two chains share the one enable so they never drift apart
    dsr_chain #(.STAGES(STAGES)) u_lane_a (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .shift_en_in(shift_en),
        .bit_in(master_q[0]),
        .tail_out(serial_a_out),
        .next_tail_out(next_tail[0])
    );

    dsr_chain #(.STAGES(STAGES)) u_lane_b (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .shift_en_in(shift_en),
        .bit_in(master_q[1]),
        .tail_out(serial_b_out),
        .next_tail_out(next_tail[1])
    );

    // Two-entry buffer; slot0 is always the head so the output is a flop
    always_comb begin
        slot0_d = slot0_q;
        slot1_d = slot1_q;
        cnt_d = cnt_q;
        case (cnt_q)
            2'h0: begin
                if (shift_en) begin
                    slot0_d = next_tail;
                    cnt_d = 2'h1;
                end
            end
            2'h1: begin
                if (shift_en && pop) begin
                    slot0_d = next_tail;
                end else if (shift_en) begin
                    slot1_d = next_tail;
                    cnt_d = 2'h2;
                end else if (pop) begin
                    cnt_d = 2'h0;
                end
            end
            2'h2: begin
                if (pop) begin
                    slot0_d = slot1_q;
                    cnt_d = 2'h1;
                end
            end
            default: begin
                cnt_d = DSR_CNT_RST;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            slot0_q <= 2'h0;
            slot1_q <= 2'h0;
            cnt_q <= DSR_CNT_RST;
            valid_q <= 1'h0;
            ready_q <= DSR_READY_RST;
        end else begin
            slot0_q <= slot0_d;
            slot1_q <= slot1_d;
            cnt_q <= cnt_d;
            valid_q <= (cnt_d != 2'h0);
            ready_q <= (cnt_d < 2'(DSR_BUF_DEPTH));
        end
    end

    assign pair_valid_out = valid_q;
    assign pair_data_out = slot0_q;
    assign shift_ready_out = ready_q;

    // Low-phase watch: the master is dynamic in the real part, so flag long lows
    always_comb begin
        low_cnt_d = 32'h0;
        overrun_d = 1'h0;
        if (!shift_clk_in) begin
            low_cnt_d = (low_cnt_q < 32'(LOW_LIMIT_CYCLES)) ? low_cnt_q + 32'h1 : low_cnt_q;
            overrun_d = (low_cnt_d >= 32'(LOW_LIMIT_CYCLES));
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            low_cnt_q <= 32'h0;
            overrun_q <= 1'h0;
        end else begin
            low_cnt_q <= low_cnt_d;
            overrun_q <= overrun_d;
        end
    end

    assign low_overrun_out = overrun_q;

    // Checks on the shift path, the master stage, the buffer and the low-phase watch
    a_master_track: assert property (@(posedge clk_in) disable iff (rst_in)
        !shift_clk_in |=> master_q[0] == $past(recirculate_select_in ? recirc_a_in : data_a_in))
        else $error("master stage did not follow lane A input while low");
    a_select_lane_b: assert property (@(posedge clk_in) disable iff (rst_in)
        (!shift_clk_in && recirculate_select_in) |=> master_q[1] == $past(recirc_b_in))
        else $error("lane B did not take the recirculation bit");
    a_master_freeze: assert property (@(posedge clk_in) disable iff (rst_in)
        (shift_clk_in && clk_prev_q) |=> master_q == $past(master_q))
        else $error("master stage moved while the clock was high");
    a_entry_bit: assert property (@(posedge clk_in) disable iff (rst_in)
        shift_en |=> u_lane_a.stage_q[0] == $past(master_q[0]))
        else $error("first stage did not take the master bit");
    a_lanes_lockstep: assert property (@(posedge clk_in) disable iff (rst_in)
        shift_en |=> u_lane_b.stage_q[0] == $past(master_q[1])
            && serial_b_out == $past(next_tail[1]))
        else $error("lane B did not shift with lane A");
    a_high_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        (shift_clk_in && clk_prev_q && !pend_q)[*2] |=> $stable(u_lane_a.stage_q))
        else $error("storage changed while the clock was parked high");
    a_tail_step: assert property (@(posedge clk_in) disable iff (rst_in)
        shift_en |=> serial_a_out == $past(u_lane_a.stage_q[STAGES-2]))
        else $error("serial output did not advance by one stage");
    a_buffer_bound: assert property (@(posedge clk_in) disable iff (rst_in)
        (cnt_q == 2'h2) |-> !shift_en && !shift_ready_out)
        else $error("shift taken while the buffer was full");
    a_overrun_low: assert property (@(posedge clk_in) disable iff (rst_in)
        low_overrun_out |-> !clk_prev_q)
        else $error("low overrun flagged after a high clock");

    c_recirc_shift: cover property (@(posedge clk_in) disable iff (rst_in)
        shift_en && recirculate_select_in);
    c_buffer_full: cover property (@(posedge clk_in) disable iff (rst_in) cnt_q == 2'h2);
    c_held_edge: cover property (@(posedge clk_in) disable iff (rst_in) pend_q ##1 shift_en);
    c_overrun: cover property (@(posedge clk_in) disable iff (rst_in) $rose(low_overrun_out));
endmodule // dsr_top

// ### logic/dsr_pkg.sv
// Constants shared by the dual recirculating shift register design.
// Assumes a single 250 MHz system clock; every figure lives here once.
package dsr_pkg;
    // Storage geometry
    localparam int DSR_STAGES = 128;
    localparam int DSR_LANES = 2;
    // System clock rate and the low-phase limit of the shift clock pin
    localparam int DSR_CLK_MHZ = 250;
    localparam int DSR_LOW_MAX_US = 100;
    // Longest time converts exactly to whole cycles
    localparam int DSR_LOW_MAX_CYC = DSR_LOW_MAX_US * DSR_CLK_MHZ;
    // Output buffer geometry
    localparam int DSR_BUF_DEPTH = 2;
    // Values after reset
    localparam logic DSR_STAGE_RST = 1'h0;
    localparam logic [1:0] DSR_CNT_RST = 2'h0;
    localparam logic DSR_READY_RST = 1'h1;
endpackage

// ### logic/dsr_chain.sv
// One serial storage chain with a one-cycle shift enable.
// Assumes the enable is already a single-cycle pulse in the clk_in domain.
`timescale 1ns/10ps
module dsr_chain
    import dsr_pkg::*;
#(
    parameter int STAGES = DSR_STAGES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Shift control and data
    input wire logic shift_en_in,
    input wire logic bit_in,
    // Chain taps
    output logic tail_out,
    output logic next_tail_out
);
    logic [STAGES-1:0] stage_q;
    logic [STAGES-1:0] stage_d;

    if (STAGES < 2) begin : g_bad_stages
        $error("dsr_chain needs at least two stages");
    end

    // Next contents: one position toward the tail per enable
    always_comb begin
        stage_d = stage_q;
        if (shift_en_in) begin
            stage_d = {stage_q[STAGES-2:0], bit_in};
        end
    end

    // Storage holds indefinitely between enables
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stage_q <= {STAGES{DSR_STAGE_RST}};
        end else begin
            stage_q <= stage_d;
        end
    end

    assign tail_out = stage_q[STAGES-1];
    assign next_tail_out = stage_q[STAGES-2];
endmodule // dsr_chain

// ### sim/dsr_host_model.sv
// Model of the driving logic: shift clock, select and data pins.
// Assumes the bench asks for one shift at a time on req_in.
`timescale 1ns/10ps
module dsr_host_model (
    // Bench side
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic req_in,
    input wire logic sel_in,
    input wire logic [1:0] bits_in,
    input wire logic [7:0] low_len_in,
    // Device side
    input wire logic ready_in,
    input wire logic [1:0] serial_in,
    output logic shift_clk_out,
    output logic sel_out,
    output logic [1:0] data_out,
    output logic [1:0] recirc_out,
    output logic busy_out
);
    logic [7:0] cnt_q;
    // Outputs looped back to the recirculation inputs, as usually wired
    assign recirc_out = serial_in;
    // Parked high from time zero, since only the high phase is static
    initial {shift_clk_out, busy_out, sel_out, data_out, cnt_q} = 13'h1000;
    // One low phase of the asked length; it never rises into a full buffer
    always @(posedge clk_in) begin
        if (rst_in) begin
            {shift_clk_out, busy_out} <= 2'h2;
        end else if (!busy_out && req_in) begin
            {busy_out, sel_out, data_out, cnt_q} <= {1'h1, sel_in, bits_in, low_len_in};
        end else if (busy_out && shift_clk_out) begin
            shift_clk_out <= 1'h0;
        end else if (busy_out && cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
        end else if (busy_out && ready_in) begin
            {shift_clk_out, busy_out} <= 2'h2;
        end
    end
endmodule // dsr_host_model

// ### sim/tb_dsr_top.sv
// Self-checking bench for dsr_top with one reference chain per lane.
// Assumes dsr_host_model drives the pins and the bench is the pair consumer.
`timescale 1ns/10ps
module tb_dsr_top
    import dsr_pkg::*;
;
    localparam int ST = 8;
    localparam int LIM = 20;
    logic clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic req = 1'h0, sel = 1'h0, pair_ready_in = 1'h0, s1 = 1'h1, s2 = 1'h1, psel = 1'h0;
    logic [1:0] bits = 2'h0, rmode = 2'h1, ppd = 2'h0;
    logic [7:0] len = 8'h01;
    logic shift_clk, rsel, busy, serial_a_out, serial_b_out;
    logic pair_valid_out, shift_ready_out, low_overrun_out;
    logic [1:0] pd, rc, pair_data_out;
    logic [ST-1:0] ha = '0, hb = '0;
    logic [1:0] exp_q[$];
    logic [15:0] lfsr = 16'h0057;
    int lc = 0, cyc = 0, err_count = 0, check_count = 0;

    // Clock at 250 MHz
    always #2 clk_in = ~clk_in;

    dsr_top #(.STAGES(ST), .LOW_LIMIT_CYCLES(LIM)) dut (
        .clk_in(clk_in), .rst_in(rst_in), .shift_clk_in(shift_clk),
        .recirculate_select_in(rsel), .data_a_in(pd[0]), .recirc_a_in(rc[0]),
        .data_b_in(pd[1]), .recirc_b_in(rc[1]), .serial_a_out(serial_a_out),
        .serial_b_out(serial_b_out), .pair_valid_out(pair_valid_out),
        .pair_data_out(pair_data_out), .pair_ready_in(pair_ready_in),
        .shift_ready_out(shift_ready_out), .low_overrun_out(low_overrun_out)
    );
    dsr_host_model host (
        .clk_in(clk_in), .rst_in(rst_in), .req_in(req), .sel_in(sel), .bits_in(bits),
        .low_len_in(len), .ready_in(shift_ready_out), .serial_in({serial_b_out, serial_a_out}),
        .shift_clk_out(shift_clk), .sel_out(rsel), .data_out(pd), .recirc_out(rc),
        .busy_out(busy)
    );

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Ask the driver for one shift; waits for it to take the request
    task automatic shift(input logic s, input logic [1:0] b, input logic [7:0] n);
        while (busy) @(posedge clk_in);
        {sel, bits, len, req} <= {s, b, n, 1'h1};
        @(posedge clk_in);
        req <= 1'h0;
        @(posedge clk_in);
    endtask

    task automatic idle();
        while (busy) @(posedge clk_in);
        repeat (4) @(posedge clk_in);
    endtask

    // Random source steps on the falling edge so all readers see one value
    always @(negedge clk_in) lfsr = lfsr_next(lfsr);
    // Consumer: stalled, random or always ready
    always @(posedge clk_in) pair_ready_in <= rmode[1] | (rmode[0] & lfsr[0]);

    // Reference chains follow the rises seen at the pin
    always @(posedge clk_in) begin
        if (rst_in) begin
            {ha, hb} = '0;
            exp_q.delete();
        end else begin
            if (shift_clk && !s1) begin
                // Entered bit is the last low-phase sample of the selected source
                ha = {ha[ST-2:0], psel ? ha[ST-1] : ppd[0]};
                hb = {hb[ST-2:0], psel ? hb[ST-1] : ppd[1]};
                exp_q.push_back({hb[ST-1], ha[ST-1]});
            end
            if (shift_clk && s1 && s2) begin
                check("serial_a", serial_a_out, ha[ST-1]);
                check("serial_b", serial_b_out, hb[ST-1]);
                check("ovr_idle", low_overrun_out, 1'h0);
            end
            // Flag is a registered level: it shows once LIM low samples lie behind this edge
            if (lc >= LIM) check("ovr_set", low_overrun_out, 1'h1);
            if (lc >= 1 && lc < LIM) begin
                check("ovr_early", low_overrun_out, 1'h0);
            end
            if (pair_valid_out && pair_ready_in) begin
                check("pair", pair_data_out, exp_q.size() > 0 ? exp_q.pop_front() : 2'bxx);
            end
        end
        {s2, s1, psel, ppd} = {s1, shift_clk, rsel, pd};
        lc = shift_clk ? 0 : lc + 1;
    end

    // Ceiling far above the few thousand cycles the sequence needs
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'h0;
        repeat (2) @(posedge clk_in);
        check("ready_rst", shift_ready_out, DSR_READY_RST);
        repeat (300) shift(lfsr[1], lfsr[3:2], {5'h0, lfsr[6:4]} + 8'h01);
        // Stall the consumer and fill both buffer entries
        rmode <= 2'h2;
        idle();
        rmode <= 2'h0;
        repeat (2) shift(1'h0, lfsr[3:2], 8'h02);
        idle();
        check("full", shift_ready_out, 1'h0);
        check("held", pair_valid_out, 1'h1);
        rmode <= 2'h1;
        // Load known bits, then rotate twice with noise on the primary inputs
        for (int i = 0; i < 3 * ST; i++) shift(i >= ST, lfsr[3:2], 8'h01);
        // One low phase past the limit; only the flag may react
        shift(1'h0, 2'h3, 8'(LIM + 6));
        idle();
        rst_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        check("valid_rst", pair_valid_out, 1'h0);
        check("ready_mid", shift_ready_out, DSR_READY_RST);
        rst_in <= 1'h0;
        repeat (40) shift(lfsr[1], lfsr[3:2], 8'h01);
        idle();
        wrap_up();
    end
endmodule // tb_dsr_top
